// >>> design/pt_repeat_pkg.sv
// constants and types for the point-table repeat sequencer
package pt_repeat_pkg;
  localparam int unsigned TBL_W      = 8;
  localparam int unsigned AUX_W      = 4;
  localparam logic [7:0]  TBL_FIRST  = 8'h01;
  localparam logic [7:0]  TBL_LAST   = 8'hff;
  localparam logic [3:0]  METHOD_ABS = 4'h0;
  localparam logic [3:0]  AUX_END_ABS  = 4'h0;
  localparam logic [3:0]  AUX_CONT_ABS = 4'h1;
  localparam logic [3:0]  AUX_END_INC  = 4'h2;
  localparam logic [3:0]  AUX_CONT_INC = 4'h3;
  localparam logic [3:0]  AUX_RPT_START_ABS = 4'h8;
  localparam logic [3:0]  AUX_RPT_ONE_ABS   = 4'h9;
  localparam logic [3:0]  AUX_RPT_START_INC = 4'ha;
  localparam logic [3:0]  AUX_RPT_ONE_INC   = 4'hb;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_FETCH,
    ST_ISSUE,
    ST_WAIT
  } seq_state_t;
endpackage

// >>> design/point_table_repeat_sequencer.sv
// point-table sequencer with automatic repeat (codes 8 to 11)
// Contract
// - code 8 or 10 loops back to start table after positioning completes.
// - code 9 or 11 loops back to table one after positioning completes.
// - repeat codes act only when method parameter last digit is zero.
// - start at selected table, step upward through consecutive tables.
// - repeating continues without count limit until stop is asserted.
// - code 8 loop-back in varying-speed operation moves clockwise.
// - code 10 on last table returns to start table, series repeats.
// - end code 0 means absolute position, code 2 incremental.
`timescale 1ns/1ns
module point_table_repeat_sequencer
  import pt_repeat_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             start,
  input  wire logic             stop,
  input  wire logic [TBL_W-1:0] start_table,
  input  wire logic [3:0]       command_method_select_parameter,
  input  wire logic [AUX_W-1:0] table_aux,
  input  wire logic             pos_done,
  output logic [TBL_W-1:0]      table_sel,
  output logic                  move_req,
  output logic                  move_incremental,
  output logic                  move_cw,
  output logic                  running,
  output logic                  looped
);
  // start, stop and pos_done pins are synchronised before use
  logic start_s1_r, start_s2_r, stop_s1_r, stop_s2_r, done_s1_r, done_s2_r;
  logic start_d_r;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      start_s1_r <= 1'b0;
      start_s2_r <= 1'b0;
      stop_s1_r  <= 1'b0;
      stop_s2_r  <= 1'b0;
      done_s1_r  <= 1'b0;
      done_s2_r  <= 1'b0;
      start_d_r  <= 1'b0;
    end else begin
      start_s1_r <= start;
      start_s2_r <= start_s1_r;
      stop_s1_r  <= stop;
      stop_s2_r  <= stop_s1_r;
      done_s1_r  <= pos_done;
      done_s2_r  <= done_s1_r;
      start_d_r  <= start_s2_r;
    end
  end
  // edge, not level, so a start held high does not rerun the series
  wire start_rise = start_s2_r & ~start_d_r;

  function automatic logic is_repeat(input logic [AUX_W-1:0] a);
    is_repeat = (a == AUX_RPT_START_ABS) || (a == AUX_RPT_ONE_ABS) ||
                (a == AUX_RPT_START_INC) || (a == AUX_RPT_ONE_INC);
  endfunction
  function automatic logic is_incr(input logic [AUX_W-1:0] a);
    is_incr = (a == AUX_END_INC) || (a == AUX_CONT_INC) ||
              (a == AUX_RPT_START_INC) || (a == AUX_RPT_ONE_INC);
  endfunction

  seq_state_t       state_r, state_nxt;
  logic [TBL_W-1:0] origin_r, origin_nxt, tbl_r, tbl_nxt;
  logic [AUX_W-1:0] aux_r, aux_nxt;
  logic             req_r, req_nxt, inc_r, inc_nxt, cw_r, cw_nxt;
  logic             run_r, run_nxt, loop_r, loop_nxt, wrap_r, wrap_nxt;
  wire abs_mode = (command_method_select_parameter == METHOD_ABS);

  always_comb begin
    state_nxt  = state_r;
    origin_nxt = origin_r;
    tbl_nxt    = tbl_r;
    aux_nxt    = aux_r;
    req_nxt    = 1'b0;
    inc_nxt    = inc_r;
    cw_nxt     = cw_r;
    run_nxt    = run_r;
    loop_nxt   = 1'b0;
    wrap_nxt   = wrap_r;
    case (state_r)
      ST_IDLE: begin
        if (start_rise && !stop_s2_r) begin
          origin_nxt = start_table;
          tbl_nxt    = start_table;
          wrap_nxt   = 1'b0;
          run_nxt    = 1'b1;
          state_nxt  = ST_FETCH;
        end
      end
      ST_FETCH: begin
        // table data arrives one cycle after the number is presented
        state_nxt = ST_ISSUE;
      end
      ST_ISSUE: begin
        aux_nxt   = table_aux;
        inc_nxt   = is_incr(table_aux);
        cw_nxt    = wrap_r;
        req_nxt   = 1'b1;
        state_nxt = ST_WAIT;
      end
      ST_WAIT: begin
        // done is a level: the drive must drop it before the next move is issued
        if (done_s2_r) begin
          wrap_nxt = 1'b0;
          if (abs_mode && is_repeat(aux_r)) begin
            loop_nxt  = 1'b1;
            wrap_nxt  = 1'b1;
            if (aux_r == AUX_RPT_START_ABS || aux_r == AUX_RPT_START_INC)
              tbl_nxt = origin_r;
            else
              tbl_nxt = TBL_FIRST;
            state_nxt = ST_FETCH;
          end else if ((aux_r == AUX_CONT_ABS || aux_r == AUX_CONT_INC)
                       && tbl_r != TBL_LAST) begin
            tbl_nxt   = tbl_r + TBL_FIRST;
            state_nxt = ST_FETCH;
          end else begin
            run_nxt   = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    // stop ends the endless loop from any state
    if (stop_s2_r) begin
      state_nxt = ST_IDLE;
      run_nxt   = 1'b0;
      req_nxt   = 1'b0;
      // a loop-back that meets stop is not reported as a repeat
      loop_nxt  = 1'b0;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r  <= ST_IDLE;
      origin_r <= TBL_FIRST;
      tbl_r    <= TBL_FIRST;
      aux_r    <= AUX_END_ABS;
      req_r    <= 1'b0;
      inc_r    <= 1'b0;
      cw_r     <= 1'b0;
      run_r    <= 1'b0;
      loop_r   <= 1'b0;
      wrap_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      origin_r <= origin_nxt;
      tbl_r    <= tbl_nxt;
      aux_r    <= aux_nxt;
      req_r    <= req_nxt;
      inc_r    <= inc_nxt;
      cw_r     <= cw_nxt;
      run_r    <= run_nxt;
      loop_r   <= loop_nxt;
      wrap_r   <= wrap_nxt;
    end
  end

  assign table_sel        = tbl_r;
  assign move_req         = req_r;
  assign move_incremental = inc_r;
  assign move_cw          = cw_r;
  assign running          = run_r;
  assign looped           = loop_r;

  // checks
  start_loop_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && done_s2_r && !stop_s2_r && abs_mode &&
     (aux_r == AUX_RPT_START_ABS || aux_r == AUX_RPT_START_INC))
    |=> (tbl_r == origin_r && looped))
    else $error("repeat to start table missed");
  one_loop_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && done_s2_r && !stop_s2_r && abs_mode &&
     (aux_r == AUX_RPT_ONE_ABS || aux_r == AUX_RPT_ONE_INC))
    |=> (tbl_r == TBL_FIRST && looped))
    else $error("repeat to table one missed");
  method_gate_a: assert property (@(posedge mclk) disable iff (rst)
    looped |-> $past(abs_mode))
    else $error("repeat outside absolute method");
  ascend_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && done_s2_r && !stop_s2_r && !is_repeat(aux_r) &&
     aux_r == AUX_CONT_ABS && tbl_r != TBL_LAST)
    |=> tbl_r == $past(tbl_r) + TBL_FIRST)
    else $error("table did not advance by one");
  endless_a: assert property (@(posedge mclk) disable iff (rst)
    looped && !stop_s2_r |-> running)
    else $error("loop ended without stop");
  cw_return_a: assert property (@(posedge mclk) disable iff (rst)
    looped && !stop_s2_r && !stop_s1_r |-> ##2 (move_req && move_cw))
    else $error("loop-back move not clockwise");
  issue_a: assert property (@(posedge mclk) disable iff (rst)
    state_r == ST_FETCH && !stop_s2_r && !stop_s1_r |-> ##2 move_req)
    else $error("table not issued after fetch");
  incr_a: assert property (@(posedge mclk) disable iff (rst)
    move_req |-> move_incremental == is_incr(aux_r))
    else $error("end code sense wrong");
  stop_a: assert property (@(posedge mclk) disable iff (rst)
    stop_s2_r |=> !running && !move_req)
    else $error("stop not honoured");
  ascend_inc_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && done_s2_r && !stop_s2_r &&
     aux_r == AUX_CONT_INC && tbl_r != TBL_LAST)
    |=> tbl_r == $past(tbl_r) + TBL_FIRST)
    else $error("incremental table did not advance");
  end_series_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && done_s2_r &&
     (aux_r == AUX_END_ABS || aux_r == AUX_END_INC))
    |=> !running && !looped)
    else $error("end code did not end series");
  method_end_a: assert property (@(posedge mclk) disable iff (rst)
    (state_r == ST_WAIT && done_s2_r && !abs_mode && is_repeat(aux_r))
    |=> !running && !looped)
    else $error("repeat taken outside absolute method");
  loop_c: cover property (@(posedge mclk) disable iff (rst) looped);
  start_c: cover property (@(posedge mclk) disable iff (rst)
    start_rise && start_table != TBL_FIRST);
  end_c: cover property (@(posedge mclk) disable iff (rst)
    $fell(running) && !stop_s2_r);
  inc_c: cover property (@(posedge mclk) disable iff (rst)
    move_req && move_incremental && move_cw);
  one_c: cover property (@(posedge mclk) disable iff (rst)
    looped && tbl_r == TBL_FIRST && origin_r != TBL_FIRST);
endmodule

// >>> dv/motion_partner.sv
// table memory and drive model answering move requests
`timescale 1ns/1ns
module motion_partner
  import pt_repeat_pkg::*;
(
  input  wire logic             mclk,
  input  wire logic [TBL_W-1:0] table_sel,
  input  wire logic             move_req,
  output logic [AUX_W-1:0]      table_aux,
  output logic                  pos_done
);
  logic [AUX_W-1:0] aux_mem [256];
  int               seed = 55;
  assign table_aux = aux_mem[table_sel];
  // random wait covers prompt and slow drives
  initial begin
    pos_done = 1'b0;
    forever begin
      @(posedge mclk iff move_req === 1'b1);
      repeat (2 + ($unsigned($random(seed)) % 20)) @(posedge mclk);
      #2 pos_done = 1'b1;
      repeat (2) @(posedge mclk);
      #2 pos_done = 1'b0;
    end
  end
endmodule

// >>> dv/testbench.sv
// self-checking bench for the point-table repeat sequencer
`timescale 1ns/1ns
module testbench;
  import pt_repeat_pkg::*;
  logic             mclk, rst, start, stop, pos_done, running, looped;
  logic             move_req, move_incremental, move_cw;
  logic [TBL_W-1:0] start_table, table_sel;
  logic [3:0]       method;
  logic [AUX_W-1:0] table_aux;
  logic [9:0]       exp_q [$];
  int               n_mismatch = 0;
  int               tests_run = 0;
  int               cyc = 0;
  int               tn = 0;
  int               n_loop = 0;
  int               seed = 55;
  point_table_repeat_sequencer dut (.mclk(mclk), .rst(rst), .start(start),
    .stop(stop), .start_table(start_table),
    .command_method_select_parameter(method), .table_aux(table_aux),
    .pos_done(pos_done), .table_sel(table_sel), .move_req(move_req),
    .move_incremental(move_incremental), .move_cw(move_cw),
    .running(running), .looped(looped));
  motion_partner far (.mclk(mclk), .table_sel(table_sel),
    .move_req(move_req), .table_aux(table_aux), .pos_done(pos_done));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic tick;
    @(posedge mclk);
    #2;
  endtask
  task automatic cmp(string nm, logic [9:0] e, logic [9:0] s);
    tests_run++;
    if (e !== s) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // aux codes of tables 1..4 packed low nibble first; at most 7 moves
  task automatic run(logic [15:0] aux, logic [7:0] st, logic [3:0] m);
    logic [7:0] t;
    logic [3:0] c;
    logic       cw;
    int         w;
    int         nl;
    int         l0;
    nl = 0;
    for (int i = 1; i < 5; i++)
      far.aux_mem[i] = aux[4*i-4 +: 4];
    t = st;
    cw = 1'b0;
    repeat (7) begin
      c = far.aux_mem[t];
      exp_q.push_back({t, c[1], cw});
      if (cw)
        nl++;
      cw = c[3] && m == 4'h0;
      if (c == 4'h1 || c == 4'h3)
        t = t + 8'h01;
      else if (cw)
        t = c[0] ? 8'h01 : st;
      else
        break;
    end
    w = exp_q.size();
    l0 = n_loop;
    start_table = st;
    method = m;
    start = 1'b1;
    tick();
    start = 1'b0;
    for (int k = 0; k < 3000 && exp_q.size() > 0; k++)
      tick();
    // a repeating series never ends by itself, so stop it
    stop = (w == 7);
    for (int k = 0; k < 60 && running !== 1'b0; k++)
      tick();
    cmp("running", 10'h000, {9'h000, running});
    cmp("left over", 10'h000, 10'(exp_q.size()));
    cmp("loops", 10'(nl), 10'(n_loop - l0));
    stop = 1'b0;
    repeat (30) tick();
    tn++;
    $display("test %0d done", tn);
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
    if (looped === 1'b1)
      n_loop++;
    if (move_req === 1'b1) begin
      if (exp_q.size() == 0)
        cmp("extra move", 10'h3ff,
            {table_sel, move_incremental, move_cw});
      else
        cmp("move", exp_q.pop_front(),
            {table_sel, move_incremental, move_cw});
    end
  end
  initial begin
    rst = 1'b1;
    start = 1'b0;
    stop = 1'b0;
    start_table = 8'h01;
    method = 4'h0;
    for (int i = 0; i < 256; i++)
      far.aux_mem[i] = 4'($random(seed));
    repeat (3) @(posedge mclk);
    #2 rst = 1'b0;
    cmp("table_sel", 10'h001, {2'b00, table_sel});
    tick();
    run(16'h8311, 8'h02, 4'h0);
    run(16'h8311, 8'h01, 4'h0);
    run(16'h0911, 8'h02, 4'h0);
    run(16'ha131, 8'h02, 4'h0);
    run(16'h0b13, 8'h02, 4'h0);
    run(16'h8311, 8'h02, 4'h1);
    run(16'h2310, 8'h02, 4'h0);
    run(16'h1101, 8'h01, 4'h0);
    run(16'h8311, 8'(1 + $unsigned($random(seed)) % 4),
        4'($random(seed) % 2));
    tally_and_finish();
  end
endmodule
